// ---- rms_sequencer.sv ----
// radio mode sequencer with its two chained interval timers
`timescale 1ns/1ns
`default_nettype none
module rms_sequencer #(
  parameter int TICK_FINE_CYC = rms_pkg::TICK_FINE_CYC,
  parameter int TICK_MID_CYC = rms_pkg::TICK_MID_CYC,
  parameter int TICK_COARSE_CYC = rms_pkg::TICK_COARSE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [rms_pkg::ADDR_W-1:0] addr,
  input wire logic [rms_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rms_pkg::DATA_W-1:0] rdata,
  input wire logic chipInSleep,
  input wire rms_pkg::rms_rx_evt_s rxEvt,
  input wire logic frameOutDone,
  input wire logic queueLevelHit,
  input wire logic queueDrained,
  input wire logic crcCheckOn,
  input wire logic badCheckAutoflush,
  input wire logic freqChanged,
  output rms_pkg::rms_chip_e chipMode,
  output rms_pkg::rms_state_e seqState,
  output logic firstTimerEvt,
  output logic secondTimerEvt,
  output logic listenRelaunch
);
  localparam int PRE_W = $clog2(TICK_COARSE_CYC + 1);

  if (TICK_FINE_CYC < 1 || TICK_MID_CYC < TICK_FINE_CYC ||
      TICK_COARSE_CYC < TICK_MID_CYC) begin : g_bad_tick
    $error("tick counts must be positive and ascending");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] seqOne_q, seqTwo_q, tmrRes_q, firstCnt_q, secondCnt_q;
  logic stopWr, launchAcc;
  rms_pkg::rms_state_e state_q, state_d;
  rms_pkg::rms_chip_e chip_d;
  logic initSleep_q, phase_q;
  logic [PRE_W-1:0] preCnt_q;
  logic [7:0] coefCnt_q;
  logic [1:0] firstRes, secondRes, curRes, startSel, toSel;
  logic [2:0] rxSel, pktSel;
  logic tmrRun, tick, expire, anyTimeout, badCheck;

  assign firstRes = tmrRes_q[rms_pkg::FIRST_RES_LO +: 2];
  assign secondRes = tmrRes_q[rms_pkg::SECOND_RES_LO +: 2];
  assign startSel = wdata[rms_pkg::START_SEL_LO +: 2];
  assign rxSel = seqTwo_q[rms_pkg::RX_EXIT_LO +: 3];
  assign toSel = seqTwo_q[rms_pkg::RXTO_EXIT_LO +: 2];
  assign pktSel = seqTwo_q[rms_pkg::PKT_EXIT_LO +: 3];
  assign stopWr = wr && addr == rms_pkg::REG_SEQ_ONE &&
                  wdata[rms_pkg::STOP_BIT];
  // launch only counts from off; stop takes priority
  assign launchAcc = wr && addr == rms_pkg::REG_SEQ_ONE &&
                     wdata[rms_pkg::LAUNCH_BIT] && !stopWr &&
                     state_q == rms_pkg::ST_OFF;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seqOne_q <= rms_pkg::SEQ_ONE_RST;
      seqTwo_q <= rms_pkg::SEQ_TWO_RST;
      tmrRes_q <= rms_pkg::TMR_RES_RST;
      firstCnt_q <= rms_pkg::TMR_CNT_RST;
      secondCnt_q <= rms_pkg::TMR_CNT_RST;
    end else if (wr) begin
      case (addr)
        // launch and stop are self-clearing strobes, not stored
        rms_pkg::REG_SEQ_ONE: seqOne_q <= {2'h0, wdata[5:0]};
        rms_pkg::REG_SEQ_TWO: seqTwo_q <= wdata;
        rms_pkg::REG_TMR_RES: tmrRes_q <= {4'h0, wdata[3:0]};
        rms_pkg::REG_TMR_ONE: firstCnt_q <= wdata;
        rms_pkg::REG_TMR_TWO: secondCnt_q <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        rms_pkg::REG_SEQ_ONE: rdata <= seqOne_q;
        rms_pkg::REG_SEQ_TWO: rdata <= seqTwo_q;
        rms_pkg::REG_TMR_RES: rdata <= tmrRes_q;
        rms_pkg::REG_TMR_ONE: rdata <= firstCnt_q;
        rms_pkg::REG_TMR_TWO: rdata <= secondCnt_q;
        rms_pkg::REG_STATUS: rdata <= {phase_q, chipMode, state_q};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------
  // interval timers
  // ----------------------------------------
  function automatic logic [PRE_W-1:0] period(input logic [1:0] res);
    case (res)
      rms_pkg::RES_FINE: period = PRE_W'(TICK_FINE_CYC - 1);
      rms_pkg::RES_MID: period = PRE_W'(TICK_MID_CYC - 1);
      default: period = PRE_W'(TICK_COARSE_CYC - 1);
    endcase
  endfunction

  // one shared prescaler: only one of the two timers runs at a time
  always_comb begin
    tmrRun = state_q != rms_pkg::ST_OFF;
    curRes = phase_q ? secondRes : firstRes;
    tick = tmrRun && curRes != rms_pkg::RES_OFF && preCnt_q == '0;
    expire = tick && coefCnt_q <= 8'h01;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 1'b0;
      preCnt_q <= '0;
      coefCnt_q <= '0;
      firstTimerEvt <= 1'b0;
      secondTimerEvt <= 1'b0;
    end else begin
      firstTimerEvt <= expire && !phase_q;
      secondTimerEvt <= expire && phase_q;
      if (launchAcc) begin
        phase_q <= 1'b0;
        preCnt_q <= period(firstRes);
        coefCnt_q <= firstCnt_q;
      end else if (expire) begin
        phase_q <= !phase_q;
        preCnt_q <= period(phase_q ? firstRes : secondRes);
        coefCnt_q <= phase_q ? firstCnt_q : secondCnt_q;
      end else if (tick) begin
        preCnt_q <= period(curRes);
        coefCnt_q <= coefCnt_q - 8'h01;
      end else if (tmrRun && curRes != rms_pkg::RES_OFF) begin
        preCnt_q <= preCnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // sequencer state machine
  // ----------------------------------------
  assign anyTimeout = rxEvt.strengthWaitExpired ||
                      rxEvt.preambleWaitExpired ||
                      rxEvt.syncWaitExpired;
  assign badCheck = rxEvt.frameInDone && crcCheckOn &&
                    !badCheckAutoflush && !rxEvt.checkPass;

  always_comb begin
    state_d = state_q;
    case (state_q)
      rms_pkg::ST_OFF: begin
        if (launchAcc) begin
          case (startSel)
            rms_pkg::START_LPS: state_d = rms_pkg::ST_LPS;
            rms_pkg::START_RX: state_d = rms_pkg::ST_RX;
            rms_pkg::START_TX: state_d = rms_pkg::ST_TX;
            default: state_d = rms_pkg::ST_WAIT;
          endcase
        end
      end
      rms_pkg::ST_WAIT:
        if (queueLevelHit) state_d = rms_pkg::ST_TX;
      rms_pkg::ST_LPS: state_d = seqOne_q[rms_pkg::LOW_PWR_BIT] ?
        rms_pkg::ST_IDLE : rms_pkg::ST_OFF;
      rms_pkg::ST_IDLE: begin
        if (firstTimerEvt) begin
          state_d = seqOne_q[rms_pkg::IDLE_EXIT_BIT] ?
            rms_pkg::ST_RX : rms_pkg::ST_TX;
        end
      end
      rms_pkg::ST_TX: begin
        if (frameOutDone) begin
          state_d = seqOne_q[rms_pkg::TX_EXIT_BIT] ?
            rms_pkg::ST_RX : rms_pkg::ST_LPS;
        end
      end
      rms_pkg::ST_RX: begin
        if (secondTimerEvt) state_d = rms_pkg::ST_LPS;
        else if (anyTimeout) state_d = rms_pkg::ST_RXTO;
        else begin
          case (rxSel)
            rms_pkg::RX_PKT_ON_DONE:
              if (rxEvt.frameInDone) state_d = rms_pkg::ST_PKT;
            rms_pkg::RX_LPS_ON_DONE:
              if (rxEvt.frameInDone) state_d = rms_pkg::ST_LPS;
            rms_pkg::RX_PKT_ON_CHECK: begin
              if (rxEvt.checkPass) state_d = rms_pkg::ST_PKT;
              else if (badCheck) state_d = rms_pkg::ST_RXTO;
            end
            rms_pkg::RX_OFF_ON_RSSI:
              if (rxEvt.strengthIrq) state_d = rms_pkg::ST_OFF;
            rms_pkg::RX_OFF_ON_SYNC:
              if (rxEvt.patternMatchEvt) state_d = rms_pkg::ST_OFF;
            rms_pkg::RX_OFF_ON_LEAD:
              if (rxEvt.leadInFound) state_d = rms_pkg::ST_OFF;
            default: ;
          endcase
        end
      end
      rms_pkg::ST_RXTO: begin
        case (toSel)
          rms_pkg::TO_RESTART: state_d = rms_pkg::ST_RX;
          rms_pkg::TO_TX: state_d = rms_pkg::ST_TX;
          rms_pkg::TO_LPS: state_d = rms_pkg::ST_LPS;
          default: state_d = rms_pkg::ST_OFF;
        endcase
      end
      rms_pkg::ST_PKT: begin
        case (pktSel)
          rms_pkg::PKT_OFF: state_d = rms_pkg::ST_OFF;
          rms_pkg::PKT_TX_DRAINED:
            if (queueDrained) state_d = rms_pkg::ST_TX;
          rms_pkg::PKT_LPS: state_d = rms_pkg::ST_LPS;
          rms_pkg::PKT_RX_VIA_FS:
            state_d = freqChanged ? rms_pkg::ST_FS : rms_pkg::ST_RX;
          rms_pkg::PKT_RX: state_d = rms_pkg::ST_RX;
          default: ;
        endcase
      end
      rms_pkg::ST_FS: state_d = rms_pkg::ST_RX;
      default: state_d = rms_pkg::ST_OFF;
    endcase
    if (stopWr) state_d = rms_pkg::ST_OFF;
  end

  // chip mode follows the state being entered; lps is transitory
  always_comb begin
    case (state_d)
      rms_pkg::ST_OFF, rms_pkg::ST_WAIT: chip_d = initSleep_q ?
        rms_pkg::CM_SLEEP : rms_pkg::CM_STDBY;
      rms_pkg::ST_IDLE: chip_d = seqOne_q[rms_pkg::IDLE_MODE_BIT] ?
        rms_pkg::CM_SLEEP : rms_pkg::CM_STDBY;
      rms_pkg::ST_TX: chip_d = rms_pkg::CM_TX;
      rms_pkg::ST_FS: chip_d = rms_pkg::CM_FS;
      rms_pkg::ST_LPS: chip_d = chipMode;
      default: chip_d = rms_pkg::CM_RX;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rms_pkg::ST_OFF;
      seqState <= rms_pkg::ST_OFF;
      chipMode <= rms_pkg::CM_SLEEP;
      listenRelaunch <= 1'b0;
    end else begin
      state_q <= state_d;
      seqState <= state_d;
      chipMode <= chip_d;
      listenRelaunch <= state_q == rms_pkg::ST_RXTO && !stopWr &&
                        toSel == rms_pkg::TO_RESTART;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) initSleep_q <= 1'b1;
    else if (launchAcc) initSleep_q <= chipInSleep;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_run;
    !stopWr;
  endsequence
  sequence s_idle_hit;
    state_q == rms_pkg::ST_IDLE && firstTimerEvt ##0 s_run;
  endsequence

  a_stop_forces_off: assert property (stopWr |=> seqState == rms_pkg::ST_OFF
    && chipMode == (initSleep_q ? rms_pkg::CM_SLEEP : rms_pkg::CM_STDBY))
    else $error("stop did not reach off");
  a_start_rx_branch: assert property (launchAcc && startSel == 
    rms_pkg::START_RX |=> seqState == rms_pkg::ST_RX ##0
    chipMode == rms_pkg::CM_RX) else $error("launch to rx failed");
  a_lps_resolves: assert property (state_q == rms_pkg::ST_LPS ##0 s_run |=>
    seqState == ($past(seqOne_q[rms_pkg::LOW_PWR_BIT]) ? rms_pkg::ST_IDLE
    : rms_pkg::ST_OFF)) else $error("lps choice wrong");
  a_idle_chip_mode: assert property (state_q == rms_pkg::ST_IDLE &&
    $past(state_q) == rms_pkg::ST_IDLE |-> chipMode ==
    ($past(seqOne_q[rms_pkg::IDLE_MODE_BIT]) ? rms_pkg::CM_SLEEP :
    rms_pkg::CM_STDBY)) else $error("idle chip mode wrong");
  a_idle_exit_sel: assert property (s_idle_hit |=> seqState ==
    ($past(seqOne_q[rms_pkg::IDLE_EXIT_BIT]) ? rms_pkg::ST_RX :
    rms_pkg::ST_TX)) else $error("idle exit wrong");
  a_idle_holds: assert property (state_q == rms_pkg::ST_IDLE &&
    !firstTimerEvt ##0 s_run |=> seqState == rms_pkg::ST_IDLE)
    else $error("idle left without first timer");
  a_tx_exit_sel: assert property (state_q == rms_pkg::ST_TX && frameOutDone
    ##0 s_run |=> seqState == ($past(seqOne_q[rms_pkg::TX_EXIT_BIT]) ?
    rms_pkg::ST_RX : rms_pkg::ST_LPS)) else $error("tx exit wrong");
  a_rx_second_tmr: assert property (state_q == rms_pkg::ST_RX &&
    secondTimerEvt ##0 s_run |=> seqState == rms_pkg::ST_LPS)
    else $error("second timer ignored in rx");
  a_rx_timeout_evt: assert property (state_q == rms_pkg::ST_RX &&
    !secondTimerEvt && anyTimeout ##0 s_run |=> seqState ==
    rms_pkg::ST_RXTO) else $error("timeout not taken");
  a_bad_check_to: assert property (state_q == rms_pkg::ST_RX && !anyTimeout
    && !secondTimerEvt && rxSel == rms_pkg::RX_PKT_ON_CHECK && badCheck
    ##0 s_run |=> seqState == rms_pkg::ST_RXTO)
    else $error("bad check missed");
  a_restart_pulse: assert property (state_q == rms_pkg::ST_RXTO &&
    toSel == rms_pkg::TO_RESTART ##0 s_run |=> seqState == rms_pkg::ST_RX
    && listenRelaunch ##1 !listenRelaunch)
    else $error("restart wrong");
  a_launch_reload: assert property (launchAcc |=> !phase_q &&
    coefCnt_q == $past(firstCnt_q)) else $error("no timer reload");
  a_timer_alternate: assert property (firstTimerEvt |-> phase_q &&
    !secondTimerEvt) else $error("timers not alternating");
  a_disabled_quiet: assert property (!phase_q && firstRes ==
    rms_pkg::RES_OFF && !launchAcc |=> !firstTimerEvt)
    else $error("disabled timer fired");
endmodule
`default_nettype wire

// ---- rms_pkg.sv ----
// package: register map, field layout, codes and timing for the sequencer
package rms_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_SEQ_ONE = 8'h00;
  localparam logic [7:0] REG_SEQ_TWO = 8'h01;
  localparam logic [7:0] REG_TMR_RES = 8'h02;
  localparam logic [7:0] REG_TMR_ONE = 8'h03;
  localparam logic [7:0] REG_TMR_TWO = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LAUNCH_BIT = 7;
  localparam int STOP_BIT = 6;
  localparam int IDLE_MODE_BIT = 5;
  localparam int START_SEL_LO = 3;
  localparam int LOW_PWR_BIT = 2;
  localparam int IDLE_EXIT_BIT = 1;
  localparam int TX_EXIT_BIT = 0;
  localparam int RX_EXIT_LO = 5;
  localparam int RXTO_EXIT_LO = 3;
  localparam int PKT_EXIT_LO = 0;
  localparam int FIRST_RES_LO = 2;
  localparam int SECOND_RES_LO = 0;
  localparam logic [7:0] SEQ_ONE_RST = 8'h00;
  localparam logic [7:0] SEQ_TWO_RST = 8'h00;
  localparam logic [7:0] TMR_RES_RST = 8'h00;
  localparam logic [7:0] TMR_CNT_RST = 8'h00;
  // ----------------------------------------
  // field codes
  // ----------------------------------------
  localparam logic [1:0] START_LPS = 2'h0;
  localparam logic [1:0] START_RX = 2'h1;
  localparam logic [1:0] START_TX = 2'h2;
  localparam logic [1:0] START_TX_LVL = 2'h3;
  localparam logic [2:0] RX_PKT_ON_DONE = 3'h1;
  localparam logic [2:0] RX_LPS_ON_DONE = 3'h2;
  localparam logic [2:0] RX_PKT_ON_CHECK = 3'h3;
  localparam logic [2:0] RX_OFF_ON_RSSI = 3'h4;
  localparam logic [2:0] RX_OFF_ON_SYNC = 3'h5;
  localparam logic [2:0] RX_OFF_ON_LEAD = 3'h6;
  localparam logic [1:0] TO_RESTART = 2'h0;
  localparam logic [1:0] TO_TX = 2'h1;
  localparam logic [1:0] TO_LPS = 2'h2;
  localparam logic [1:0] TO_OFF = 2'h3;
  localparam logic [2:0] PKT_OFF = 3'h0;
  localparam logic [2:0] PKT_TX_DRAINED = 3'h1;
  localparam logic [2:0] PKT_LPS = 3'h2;
  localparam logic [2:0] PKT_RX_VIA_FS = 3'h3;
  localparam logic [2:0] PKT_RX = 3'h4;
  localparam logic [1:0] RES_OFF = 2'h0;
  localparam logic [1:0] RES_FINE = 2'h1;
  localparam logic [1:0] RES_MID = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_FINE_NS = 64000;
  localparam int TICK_MID_NS = 4100000;
  localparam int TICK_COARSE_NS = 262000000;
  localparam int TICK_FINE_CYC = TICK_FINE_NS / CLK_PERIOD_NS;
  localparam int TICK_MID_CYC = TICK_MID_NS / CLK_PERIOD_NS;
  localparam int TICK_COARSE_CYC = TICK_COARSE_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_OFF, ST_IDLE, ST_TX, ST_RX, ST_PKT, ST_LPS, ST_RXTO, ST_FS, ST_WAIT
  } rms_state_e;
  typedef enum logic [2:0] {
    CM_SLEEP, CM_STDBY, CM_FS, CM_TX, CM_RX
  } rms_chip_e;
  typedef struct packed {
    logic strengthIrq;
    logic patternMatchEvt;
    logic leadInFound;
    logic strengthWaitExpired;
    logic preambleWaitExpired;
    logic syncWaitExpired;
    logic frameInDone;
    logic checkPass;
  } rms_rx_evt_s;
endpackage

// ---- rms_sequencer_tb_top.sv ----
// self-checking testbench for the radio mode sequencer
`timescale 1ns/1ns
`default_nettype none
module rms_sequencer_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk, reset_n, wr, rd, chipInSleep, frameOutDone, queueLevelHit;
  logic queueDrained, crcCheckOn, badCheckAutoflush, freqChanged;
  logic [7:0] addr, wdata, rdata, rv;
  rms_pkg::rms_rx_evt_s rxEvt;
  rms_pkg::rms_chip_e chipMode;
  rms_pkg::rms_state_e seqState;
  logic firstTimerEvt, secondTimerEvt, listenRelaunch;
  int nMismatch = 0;
  int samplesChecked = 0;
  int n;
  // receive table: event index and expected next state per exit code
  int rxEv [8] = '{6, 6, 6, 7, 0, 1, 2, 6};
  rms_pkg::rms_state_e rxExp [8] = '{rms_pkg::ST_RX, rms_pkg::ST_PKT,
    rms_pkg::ST_LPS, rms_pkg::ST_PKT, rms_pkg::ST_OFF, rms_pkg::ST_OFF,
    rms_pkg::ST_OFF, rms_pkg::ST_RX};
  rms_pkg::rms_state_e toExp [4] = '{rms_pkg::ST_RX, rms_pkg::ST_TX,
    rms_pkg::ST_LPS, rms_pkg::ST_OFF};
  rms_pkg::rms_state_e pkExp [5] = '{rms_pkg::ST_OFF, rms_pkg::ST_TX,
    rms_pkg::ST_LPS, rms_pkg::ST_FS, rms_pkg::ST_RX};

  // short tick sizes keep the timer scenarios within a few hundred cycles
  rms_sequencer #(
    .TICK_FINE_CYC(4),
    .TICK_MID_CYC(8),
    .TICK_COARSE_CYC(16)
  ) uut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .chipInSleep(chipInSleep), .rxEvt(rxEvt),
    .frameOutDone(frameOutDone), .queueLevelHit(queueLevelHit),
    .queueDrained(queueDrained), .crcCheckOn(crcCheckOn),
    .badCheckAutoflush(badCheckAutoflush), .freqChanged(freqChanged),
    .chipMode(chipMode), .seqState(seqState),
    .firstTimerEvt(firstTimerEvt), .secondTimerEvt(secondTimerEvt),
    .listenRelaunch(listenRelaunch)
  );

  always #25 clk = ~clk;

  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task testDone;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chks(input rms_pkg::rms_state_e e);
    chk(8'(seqState), 8'(e));
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  task wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // 0..7 receiver events (struct msb first), 8 sent, 9 level, 10 drained
  task pulse(input int i);
    @(posedge clk);
    if (i < 8) rxEvt[7-i] <= 1'b1;
    if (i == 8) frameOutDone <= 1'b1;
    if (i == 9) queueLevelHit <= 1'b1;
    if (i == 10) queueDrained <= 1'b1;
    @(posedge clk);
    rxEvt <= '0;
    frameOutDone <= 1'b0;
    queueLevelHit <= 1'b0;
    queueDrained <= 1'b0;
    #1;
  endtask

  // cycles until the chosen timer pulse, lim if it never comes
  task waitEvt(input int which, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      tick();
      cnt++;
      if ((which == 0 ? firstTimerEvt : secondTimerEvt) === 1'b1) break;
    end
  endtask

  task stopSeq;
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h40);
    chks(rms_pkg::ST_OFF);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0; reset_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00;
    wdata = 8'h00; rxEvt = '0; frameOutDone = 1'b0; queueLevelHit = 1'b0;
    queueDrained = 1'b0; crcCheckOn = 1'b0; badCheckAutoflush = 1'b0;
    freqChanged = 1'b0; chipInSleep = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tick();
    chks(rms_pkg::ST_OFF);
    rdReg(8'h0F, rv);
    chk(rv, 8'h00);
    wrReg(rms_pkg::REG_TMR_ONE, 8'h03);
    rdReg(rms_pkg::REG_TMR_ONE, rv);
    chk(rv, 8'h03);
    // launch from standby, straight back off: standby restored
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h80);
    chks(rms_pkg::ST_LPS);
    tick();
    chks(rms_pkg::ST_OFF);
    chk(8'(chipMode), 8'(rms_pkg::CM_STDBY));
    // launch from sleep: sleep comes back at off
    chipInSleep <= 1'b1;
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h80);
    tick();
    chk(8'(chipMode), 8'(rms_pkg::CM_SLEEP));
    chipInSleep <= 1'b0;
    // idle, sleep then standby, deaf to all but the first timer
    wrReg(rms_pkg::REG_SEQ_ONE, 8'hA4);
    tick();
    chks(rms_pkg::ST_IDLE);
    tick();
    chk(8'(chipMode), 8'(rms_pkg::CM_SLEEP));
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h04);
    tick();
    chk(8'(chipMode), 8'(rms_pkg::CM_STDBY));
    pulse(8);
    pulse(6);
    pulse(10);
    chks(rms_pkg::ST_IDLE);
    stopSeq();
    // chained timers: first 3 fine ticks, second 2 fine ticks
    wrReg(rms_pkg::REG_TMR_RES, 8'h05);
    wrReg(rms_pkg::REG_TMR_ONE, 8'h03);
    wrReg(rms_pkg::REG_TMR_TWO, 8'h02);
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h85);
    waitEvt(0, 60, n);
    chk(8'(n >= 11 && n <= 15), 8'h01);
    tick();
    chks(rms_pkg::ST_TX);
    pulse(8);
    chks(rms_pkg::ST_RX);
    waitEvt(1, 60, n);
    chk(8'(n >= 4 && n <= 10), 8'h01);
    tick();
    chks(rms_pkg::ST_LPS);
    waitEvt(0, 60, n);
    chk(8'(n >= 9 && n <= 15), 8'h01);
    stopSeq();
    // disabled first timer never fires
    wrReg(rms_pkg::REG_TMR_RES, 8'h00);
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h84);
    waitEvt(0, 100, n);
    chk(8'(n), 8'd100);
    stopSeq();
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h90);
    chks(rms_pkg::ST_TX);
    stopSeq();
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h98);
    chks(rms_pkg::ST_WAIT);
    pulse(9);
    chks(rms_pkg::ST_TX);
    stopSeq();
    // every receive exit code with its own event
    for (int k = 0; k < 8; k++) begin
      wrReg(rms_pkg::REG_SEQ_TWO, 8'(k << 5));
      wrReg(rms_pkg::REG_SEQ_ONE, 8'h88);
      pulse(rxEv[k]);
      chks(rxExp[k]);
      stopSeq();
    end
    // bad check sends payload-ready to the timeout branch
    crcCheckOn <= 1'b1;
    wrReg(rms_pkg::REG_SEQ_TWO, 8'h78);
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h88);
    pulse(6);
    chks(rms_pkg::ST_RXTO);
    tick();
    chks(rms_pkg::ST_OFF);
    crcCheckOn <= 1'b0;
    // all timeout branches, each of the three waits
    for (int t = 0; t < 4; t++) begin
      for (int w = 3; w < 6; w++) begin
        wrReg(rms_pkg::REG_SEQ_TWO, 8'(8'h20 | (t << 3)));
        wrReg(rms_pkg::REG_SEQ_ONE, 8'h88);
        pulse(w);
        chks(rms_pkg::ST_RXTO);
        tick();
        chks(toExp[t]);
        if (t == 0) chk(8'(listenRelaunch), 8'h01);
        else chk(8'(listenRelaunch), 8'h00);
        stopSeq();
      end
    end
    // packet-held branches, frequency changed
    freqChanged <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      wrReg(rms_pkg::REG_SEQ_TWO, 8'(8'h20 | p));
      wrReg(rms_pkg::REG_SEQ_ONE, 8'h88);
      pulse(6);
      chks(rms_pkg::ST_PKT);
      if (p == 1) pulse(10);
      else tick();
      chks(pkExp[p]);
      if (p == 3) begin
        tick();
        chks(rms_pkg::ST_RX);
      end
      stopSeq();
    end
    // packet-held via synthesizer code, frequency unchanged
    freqChanged <= 1'b0;
    wrReg(rms_pkg::REG_SEQ_TWO, 8'h23);
    wrReg(rms_pkg::REG_SEQ_ONE, 8'h88);
    pulse(6);
    chks(rms_pkg::ST_PKT);
    tick();
    chks(rms_pkg::ST_RX);
    stopSeq();
    testDone();
  end

  initial begin
    #(50 * 20000);
    nMismatch++;
    testDone();
  end
endmodule
`default_nettype wire
